//--- rtl/nand_irq_cfg.svh
// Register map, field positions and reset value of the interrupt block
`ifndef NAND_IRQ_CFG_SVH
`define NAND_IRQ_CFG_SVH
`define IRQ_EN_OFFSET 12'h120
`define IRQ_CLEAR_OFFSET 12'h124
`define IRQ_STATUS_OFFSET 12'h128
`define IRQ_ECC_THRESH_OFFSET 12'h12c
`define IRQ_PAGE_NUM_OFFSET 12'h130
`define IRQ_SRC_COUNT 10
`define IRQ_RESET_VALUE 32'h0000_0000
`define IRQ_BIT_DMA_DONE 0
`define IRQ_BIT_FLASH_READY 1
`define IRQ_BIT_ECC_ERROR 2
`define IRQ_BIT_ECC_FAIL 3
`define IRQ_BIT_LIST_DONE 4
`define IRQ_BIT_READ_ABORT 5
`define IRQ_BIT_MASTER_IDLE 6
`define IRQ_BIT_FIRST_PAGE 7
`define IRQ_BIT_SEED_FAIL 8
`define IRQ_BIT_SEED_ERROR 9
`define ECC_THRESH_LSB 19
`define ECC_THRESH_MSB 26
`define PAGE_NUM_LSB 22
`define PAGE_NUM_MSB 27
`endif

//--- rtl/nand_irq_pkg.sv
// Types shared by the interrupt block
package nand_irq_pkg;
  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_SETUP,
    BUS_ACCESS
  } bus_phase_type;
endpackage : nand_irq_pkg

//--- rtl/nand_irq_flag.sv
// One sticky pending flag with set-over-clear priority
`timescale 1ns/1ps
module nand_irq_flag (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Event and clear
  input wire logic set_i,
  input wire logic clear_i,
  // Pending flag
  output logic pending_o
);
  // A set in the clear cycle wins so no event is lost
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pending_o <= 1'b0;
    else if (set_i)
      pending_o <= 1'b1;
    else if (clear_i)
      pending_o <= 1'b0;
  end
endmodule : nand_irq_flag

//--- rtl/nand_irq_ctrl.sv
// Interrupt status, clear and enable registers of the NAND flash controller
//
// Behaviour
// - clear register bits 9..0 reset to zero, self-clear; 31..10 reserved, read zero.
// - status register read-only, one active-high pending flag per source, bits 9..0.
// - status bit 9 is backup-seed ECC error; clear bit 9 removes it.
// - status bit 8 is backup-seed ECC failure; clear bit 8 removes it.
// - status bit 7 is first page read done; write one clears it.
// - status bit 6 is master idle; write one clears it.
// - bit 5 is flash read abort, only in synchronous or toggle modes.
// - status bit 4 is linked-list operation done; write one clears it.
// - status bit 3 is ECC decode failure; clear bit 3 removes it.
// - status bit 2 is ECC decode error; clear bit 2 removes it.
// - status bit 1 is flash ready; clear bit 1 removes it.
// - status bit 0 is internal DMA done; clear bit 0 removes it.
// - flash ready event fires on low-to-high of ready/busy input.
// - master idle event fires on rising edge of idle indication.
// - ECC error event fires when corrected bits exceed threshold field.
// - DMA done event fires when programmed page count is transferred.
`timescale 1ns/1ps
`include "nand_irq_cfg.svh"
module nand_irq_ctrl #(
  parameter int SRC_COUNT = `IRQ_SRC_COUNT
) (
  // Clock and reset
  input wire logic MCLK_I,
  input wire logic RST_I,
  // APB slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // Event sources
  input wire logic SEED_ECC_ERROR_I,
  input wire logic SEED_ECC_FAIL_I,
  input wire logic FIRST_PAGE_DONE_I,
  input wire logic MASTER_IDLE_I,
  input wire logic READ_ABORT_I,
  input wire logic SYNC_OR_TOGGLE_MODE_I,
  input wire logic LIST_DONE_I,
  input wire logic ECC_FAIL_I,
  input wire logic ECC_DONE_I,
  input wire logic [7:0] ECC_ERR_COUNT_I,
  input wire logic FLASH_READY_I,
  input wire logic DMA_MODE_I,
  input wire logic PAGE_DONE_I,
  // Interrupt
  output logic IRQ_O
);
  logic [SRC_COUNT-1:0] enable_q;
  logic [SRC_COUNT-1:0] clear_q;
  logic [SRC_COUNT-1:0] pending;
  logic [SRC_COUNT-1:0] event_set;
  logic [7:0] ecc_thresh_q;
  logic [5:0] page_num_q;
  logic [5:0] page_count_q;
  logic [5:0] page_count_d;
  logic ready_prev_q;
  logic idle_prev_q;
  logic dma_done;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  nand_irq_pkg::bus_phase_type phase_q;

  // Bus phase, kept for visibility of protocol state; slave answers with no wait
  always_ff @(posedge MCLK_I)
  begin
    if (RST_I)
      phase_q <= nand_irq_pkg::BUS_IDLE;
    else if (PSEL_I && !PENABLE_I)
      phase_q <= nand_irq_pkg::BUS_SETUP;
    else if (PSEL_I && PENABLE_I)
      phase_q <= nand_irq_pkg::BUS_ACCESS;
    else
      phase_q <= nand_irq_pkg::BUS_IDLE;
  end

  // Decode; PREADY is always high so every access completes in its first access cycle
  always_comb
  begin
    addr_ok = (PADDR_I == `IRQ_EN_OFFSET) || (PADDR_I == `IRQ_CLEAR_OFFSET) ||
              (PADDR_I == `IRQ_STATUS_OFFSET) || (PADDR_I == `IRQ_ECC_THRESH_OFFSET) ||
              (PADDR_I == `IRQ_PAGE_NUM_OFFSET);
    wr_en = PSEL_I && PENABLE_I && PWRITE_I && addr_ok;
    rd_en = PSEL_I && !PENABLE_I && !PWRITE_I;
  end
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = PSEL_I && PENABLE_I && !addr_ok;

  // Read data registered at the setup cycle, valid throughout the access phase
  always_ff @(posedge MCLK_I)
  begin
    if (RST_I)
      PRDATA_O <= `IRQ_RESET_VALUE;
    else if (rd_en)
    begin
      unique case (PADDR_I)
        `IRQ_EN_OFFSET: PRDATA_O <= 32'(enable_q);
        `IRQ_CLEAR_OFFSET: PRDATA_O <= 32'(clear_q);
        `IRQ_STATUS_OFFSET: PRDATA_O <= 32'(pending);
        `IRQ_ECC_THRESH_OFFSET: PRDATA_O <= 32'(ecc_thresh_q) << `ECC_THRESH_LSB;
        `IRQ_PAGE_NUM_OFFSET: PRDATA_O <= 32'(page_num_q) << `PAGE_NUM_LSB;
        default: PRDATA_O <= 32'h0000_0000;
      endcase
    end
  end

  // Enable and configuration registers written by software
  always_ff @(posedge MCLK_I)
  begin
    if (RST_I)
    begin
      enable_q <= '0;
      ecc_thresh_q <= 8'h00;
      page_num_q <= 6'h00;
    end
    else if (wr_en)
    begin
      if (PADDR_I == `IRQ_EN_OFFSET)
        enable_q <= PWDATA_I[SRC_COUNT-1:0];
      if (PADDR_I == `IRQ_ECC_THRESH_OFFSET)
        ecc_thresh_q <= PWDATA_I[`ECC_THRESH_MSB:`ECC_THRESH_LSB];
      if (PADDR_I == `IRQ_PAGE_NUM_OFFSET)
        page_num_q <= PWDATA_I[`PAGE_NUM_MSB:`PAGE_NUM_LSB];
    end
  end

  // Clear pulses last one cycle; zero bits are ignored
  always_ff @(posedge MCLK_I)
  begin
    if (RST_I)
      clear_q <= '0;
    else if (wr_en && PADDR_I == `IRQ_CLEAR_OFFSET)
      clear_q <= PWDATA_I[SRC_COUNT-1:0];
    else
      clear_q <= '0;
  end

  // Edge history of level sources
  always_ff @(posedge MCLK_I)
  begin
    if (RST_I)
    begin
      ready_prev_q <= 1'b0;
      idle_prev_q <= 1'b0;
    end
    else
    begin
      ready_prev_q <= FLASH_READY_I;
      idle_prev_q <= MASTER_IDLE_I;
    end
  end

  // Page counter for DMA transfers; a zero page count never completes
  always_comb
  begin
    page_count_d = page_count_q;
    if (!DMA_MODE_I)
      page_count_d = 6'h00;
    else if (PAGE_DONE_I)
      page_count_d = dma_done ? 6'h00 : page_count_q + 6'h01;
  end
  assign dma_done = DMA_MODE_I && PAGE_DONE_I && (page_num_q != 6'h00) &&
                    (page_count_q + 6'h01 == page_num_q);
  always_ff @(posedge MCLK_I)
  begin
    if (RST_I)
      page_count_q <= 6'h00;
    else
      page_count_q <= page_count_d;
  end

  // Event vector in status bit order
  always_comb
  begin
    event_set = '0;
    event_set[`IRQ_BIT_SEED_ERROR] = SEED_ECC_ERROR_I;
    event_set[`IRQ_BIT_SEED_FAIL] = SEED_ECC_FAIL_I;
    event_set[`IRQ_BIT_FIRST_PAGE] = FIRST_PAGE_DONE_I;
    event_set[`IRQ_BIT_MASTER_IDLE] = MASTER_IDLE_I && !idle_prev_q;
    // Abort only means something in the synchronous and toggle interfaces
    event_set[`IRQ_BIT_READ_ABORT] = READ_ABORT_I && SYNC_OR_TOGGLE_MODE_I;
    event_set[`IRQ_BIT_LIST_DONE] = LIST_DONE_I;
    event_set[`IRQ_BIT_ECC_FAIL] = ECC_FAIL_I;
    event_set[`IRQ_BIT_ECC_ERROR] = ECC_DONE_I && (ECC_ERR_COUNT_I > ecc_thresh_q);
    event_set[`IRQ_BIT_FLASH_READY] = FLASH_READY_I && !ready_prev_q;
    event_set[`IRQ_BIT_DMA_DONE] = dma_done;
  end

  // One sticky flag per source
  for (genvar i = 0; i < SRC_COUNT; i++)
  begin : g_flag
    nand_irq_flag u_flag (
      .clk_i(MCLK_I),
      .rst_i(RST_I),
      .set_i(event_set[i]),
      .clear_i(clear_q[i]),
      .pending_o(pending[i])
    );
  end

  // Level interrupt from enabled pending flags
  always_ff @(posedge MCLK_I)
  begin
    if (RST_I)
      IRQ_O <= 1'b0;
    else
      IRQ_O <= |(pending & enable_q);
  end
endmodule : nand_irq_ctrl

//--- sim/nand_irq_chk.sv
// Port checks for the interrupt status and clear block
`timescale 1ns/1ps
module nand_irq_chk (
  // Clock, reset and bus request
  input wire logic MCLK_I,
  input wire logic RST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  // Answers and interrupt
  input wire logic [31:0] PRDATA_O,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  input wire logic IRQ_O
);
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (RST_I);
  // Decode once so all checks but the reserved-bit and reset ones stay on one line
  wire acc = PSEL_I && PENABLE_I;
  wire rset = PSEL_I && !PENABLE_I && !PWRITE_I;
  wire hit = PADDR_I inside {12'h120, 12'h124, 12'h128, 12'h12c, 12'h130};
  ready_high_a: assert property (PREADY_O) else $error("pready low");
  bad_addr_a: assert property (acc && !hit |-> PSLVERR_O) else $error("no slverr");
  good_addr_a: assert property (acc && hit |-> !PSLVERR_O) else $error("bad slverr");
  hole_read_a: assert property (rset && !hit |=> PRDATA_O == 32'h0) else $error("hole data");
  stat_rsvd_a:
    assert property (rset && PADDR_I == 12'h128 |=> PRDATA_O[31:10] == 22'h0)
    else $error("status reserved set");
  clr_rsvd_a:
    assert property (rset && PADDR_I == 12'h124 |=> PRDATA_O[31:10] == 22'h0)
    else $error("clear reserved set");
  rdata_hold_a: assert property (!rset |=> $stable(PRDATA_O)) else $error("rdata moved");
  // Reset must win over any pending flag, so its own disable is switched off
  reset_out_a:
    assert property (disable iff (1'b0) $past(RST_I) |-> !IRQ_O && PRDATA_O == 32'h0)
    else $error("outputs not reset");
endmodule : nand_irq_chk

bind nand_irq_ctrl nand_irq_chk chk (.MCLK_I, .RST_I, .PSEL_I, .PENABLE_I, .PWRITE_I,
  .PADDR_I, .PRDATA_O, .PREADY_O, .PSLVERR_O, .IRQ_O);

//--- sim/nand_irq_ctrl_tb.sv
// Self-checking bench for the interrupt status and clear block
`timescale 1ns/1ps
module nand_irq_ctrl_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic sync = 1'b1;
  logic [11:0] padr = 12'h0;
  logic [31:0] pwd = 32'h0;
  logic [9:0] ev = 10'h0;
  logic [7:0] cnt = 8'h0;
  logic [31:0] rdata;
  logic rdy;
  logic irq;
  logic [31:0] exp_q[$];
  int err_total = 0;
  int check_count = 0;
  int cyc = 0;
  int t;
  int k;
  // 100 MHz clock
  always #5 clk = ~clk;
  nand_irq_ctrl dut (
    .MCLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
    .PADDR_I(padr), .PWDATA_I(pwd), .PRDATA_O(rdata), .PREADY_O(rdy), .PSLVERR_O(),
    .SEED_ECC_ERROR_I(ev[9]), .SEED_ECC_FAIL_I(ev[8]), .FIRST_PAGE_DONE_I(ev[7]),
    .MASTER_IDLE_I(ev[6]), .READ_ABORT_I(ev[5]), .SYNC_OR_TOGGLE_MODE_I(sync),
    .LIST_DONE_I(ev[4]), .ECC_FAIL_I(ev[3]), .ECC_DONE_I(ev[2]), .ECC_ERR_COUNT_I(cnt),
    .FLASH_READY_I(ev[1]), .DMA_MODE_I(1'b1), .PAGE_DONE_I(ev[0]), .IRQ_O(irq));
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    check_count++;
    if (seen !== want)
    begin
      err_total++;
      $display("mismatch at %0t: got %h want %h", $time, seen, want);
    end
  endtask : chk
  // One APB transfer; for a read, d is the expected data
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    if (!w)
      exp_q.push_back(d);
    psel <= 1'b1;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (rdy !== 1'b1);
    // Idle edge between transfers so select is never driven twice in one step
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : xfer
  // One-cycle event pulse, then time for flag and interrupt to land
  task automatic pulse(input logic [9:0] v);
    ev <= v;
    @(posedge clk);
    ev <= 10'h0;
    repeat (3) @(posedge clk);
  endtask : pulse
  // Look at the level mid-cycle, away from the edge
  task automatic irq_is(input logic b);
    @(negedge clk);
    chk({31'h0, irq}, {31'h0, b});
    @(posedge clk);
  endtask : irq_is
  task automatic print_verdict;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : print_verdict
  // Read data monitor: oldest note against what the bus returns
  always @(posedge clk)
  begin
    if (psel && pen && !pwr && rdy === 1'b1)
      chk(rdata, exp_q.pop_front());
  end
  // Hang guard, well above the expected run of a few hundred cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc > 3000)
    begin
      err_total++;
      print_verdict();
    end
  end
  initial
  begin
    t = $urandom(56777);
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    xfer(0, 12'h124, 32'h0);
    xfer(0, 12'h128, 32'h0);
    xfer(0, 12'h200, 32'h0);
    t = $urandom % 255;
    cnt <= t[7:0];
    xfer(1, 12'h12c, t << 19);
    xfer(1, 12'h130, 32'h1 << 22);
    // Abort outside sync mode and a count equal to threshold both stay quiet
    sync <= 1'b0;
    pulse(10'h024);
    xfer(0, 12'h128, 32'h0);
    sync <= 1'b1;
    cnt <= t[7:0] + 8'h1;
    for (int i = 0; i < 10; i++)
    begin
      pulse(10'h1 << i);
      xfer(1, 12'h128, 32'h0);
      xfer(1, 12'h124, ~(32'h1 << i));
      repeat (2) @(posedge clk);
      xfer(0, 12'h128, 32'h1 << i);
      xfer(1, 12'h124, 32'h1 << i);
      repeat (2) @(posedge clk);
      xfer(0, 12'h128, 32'h0);
    end
    k = $urandom % 10;
    xfer(1, 12'h120, 32'h1 << k);
    pulse(~(10'h1 << k));
    irq_is(1'b0);
    pulse(10'h1 << k);
    irq_is(1'b1);
    xfer(1, 12'h124, 32'h3ff);
    repeat (3) @(posedge clk);
    irq_is(1'b0);
    print_verdict();
  end
endmodule : nand_irq_ctrl_tb
